// ==== core/cable_driver_params.svh ====
/*
 * Offsets, fields, reset values and bus codes of the cable driver control.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef CABLE_DRIVER_PARAMS_SVH
`define CABLE_DRIVER_PARAMS_SVH

// Byte offsets; management register n sits at 4n
`define OFS_CTRL            8'h00
`define OFS_TRIM            8'h04
`define OFS_STATUS          8'h08
`define OFS_BUSADDR         8'h0C

// Control register fields
`define CTRL_SLOW_EDGE      0
`define CTRL_LOS_MUTE       1
`define CTRL_LOS_PWRDN      2
`define CTRL_MASK_LOS       3
`define CTRL_MASK_TERM      4
`define CTRL_WIDTH          5

// Status register fields
`define STAT_LOS            0
`define STAT_TERM           1
`define STAT_CHAIN          2
`define STAT_FAULT          3
`define STAT_DRIVER_ON      4
`define STAT_SLOW_EDGE      5

// Reset values
`define CTRL_RESET          5'h00
`define TRIM_RESET          6'h00
`define BUSADDR_RESET       7'h17

// Trim: signed 5 mV steps, limit 10 % of 800 mV
`define TRIM_WIDTH          6
`define TRIM_LIMIT          6'h10

// Internal pull levels
`define PULL_CHAIN_RESET    1'h1
`define PULL_ENABLE         1'h1
`define PULL_EDGE_RATE      1'h0

// AXI4-Lite responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== core/cable_driver_pkg.sv ====
/*
 * Types shared by the cable driver control logic and its management bus target.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cable_driver_pkg;

    typedef enum logic [5:0] {
        SMB_IDLE   = 6'b000001,
        SMB_ADDR   = 6'b000010,
        SMB_CMD    = 6'b000100,
        SMB_WDAT   = 6'b001000,
        SMB_RDAT   = 6'b010000,
        SMB_IGNORE = 6'b100000
    } smb_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] idx;
        logic [7:0] data;
    } smb_wr_t;

    typedef struct packed {
        logic input_signal_loss;
        logic term;
        logic enable;
        logic edge_rate;
        logic chain_reset_n;
    } pin_level_t;

endpackage

// ==== core/smbus_target.sv ====
/*
 * Management bus target: start/stop detection, address match, command byte, byte writes and reads.
 * Assumes SCL and SDA are asynchronous and far slower than ref_clk_i; SDA is pulled up outside.
 */
module smbus_target (
    // Clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    // Bus pins
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output logic                          sda_oe_o,
    // Register side
    input  wire logic [6:0]               bus_addr_i,
    input  wire logic [7:0]               rdata_i,
    output logic [7:0]                    idx_o,
    output cable_driver_pkg::smb_wr_t     wr_o
);
    import cable_driver_pkg::*;

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    smb_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] idx_reg;
    logic [7:0] rd_reg;
    logic       rw_reg;
    logic       oe_reg;
    smb_wr_t    wr_reg;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    // Reset to the idle bus level so no false start follows
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'h1;
            sda_d_reg    <= 1'h1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    assign scl_rise   = scl_sync_reg[1] & ~scl_d_reg;
    assign scl_fall   = ~scl_sync_reg[1] & scl_d_reg;
    assign start_seen = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
    assign stop_seen  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= SMB_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            idx_reg   <= 8'h00;
            rd_reg    <= 8'h00;
            rw_reg    <= 1'h0;
            oe_reg    <= 1'h0;
            wr_reg    <= '0;
        end else begin
            wr_reg.valid <= 1'h0;
            if (start_seen) begin
                state_reg <= SMB_ADDR;
                cnt_reg   <= 4'h0;
                oe_reg    <= 1'h0;
            end else if (stop_seen) begin
                state_reg <= SMB_IDLE;
                oe_reg    <= 1'h0;
            end else if (scl_rise) begin
                cnt_reg   <= cnt_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
            end else if (scl_fall) begin
                if (cnt_reg == 4'h8) begin
                    // Acknowledge phase: pull low only, never drive high
                    case (state_reg)
                        SMB_ADDR: begin
                            rw_reg <= shift_reg[0];
                            if (shift_reg[7:1] == bus_addr_i) begin
                                oe_reg <= 1'h1;
                            end else begin
                                state_reg <= SMB_IGNORE;
                            end
                        end
                        SMB_CMD: begin
                            oe_reg  <= 1'h1;
                            idx_reg <= shift_reg;
                        end
                        SMB_WDAT: begin
                            oe_reg <= 1'h1;
                            wr_reg <= '{valid: 1'h1, idx: idx_reg, data: shift_reg};
                        end
                        SMB_RDAT: oe_reg <= 1'h0;
                        default: ;
                    endcase
                end else if (cnt_reg == 4'h9) begin
                    cnt_reg <= 4'h0;
                    oe_reg  <= 1'h0;
                    case (state_reg)
                        SMB_ADDR: begin
                            if (rw_reg) begin
                                state_reg <= SMB_RDAT;
                                rd_reg    <= rdata_i;
                                oe_reg    <= ~rdata_i[7];
                            end else begin
                                state_reg <= SMB_CMD;
                            end
                        end
                        SMB_CMD: state_reg <= SMB_WDAT;
                        SMB_WDAT: idx_reg <= idx_reg + 8'h01;
                        SMB_RDAT: begin
                            // One byte per read; a host ACK still steps the index
                            state_reg <= SMB_IGNORE;
                            if (!shift_reg[0]) begin
                                idx_reg <= idx_reg + 8'h01;
                            end
                        end
                        default: ;
                    endcase
                end else if (state_reg == SMB_RDAT) begin
                    oe_reg <= ~rd_reg[6];
                    rd_reg <= {rd_reg[6:0], 1'h1};
                end
            end
        end
    end

    assign sda_oe_o = oe_reg;
    assign idx_o    = idx_reg;
    assign wr_o     = wr_reg;

endmodule // smbus_target

// ==== core/cable_driver_ctrl.sv ====
/*
 * Control and status logic of a serial-video cable driver: chained reset, driver enable,
 * edge-rate choice, open-drain fault flag, amplitude trim and status over AXI4-Lite and the management bus.
 * Assumes pins are asynchronous to ref_clk_i; each pulled pin comes
 * with a flag that is high while undriven; open-drain lines are pulled up outside.
 */
//
// Contract
// - Low reset input holds configuration at defaults
// - Reset input pulled up when undriven
// - Low reset input forces chain output low
// - Register 0 write sets chain output
// - Low enable powers off output driver
// - Enable input pulled up when undriven
// - High edge select gives slow edges
// - Low edge select gives fast edges
// - Edge select pulled down when undriven
// - Fault flag low on loss or termination
// - Fault flag open drain, wire-OR capable
// - Data line only pulls low
// - Clock line input only
// - Amplitude trim plus/minus ten percent, 5 mV steps
// - Loss and cable status readable
// - Bus address 0x17, changeable
// - Each fault source maskable from flag
// - Register edge bit works only with pin low
// - Signal loss adds offset or mutes
//
`include "cable_driver_params.svh"

module cable_driver_ctrl (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // Strap-like pins with their undriven flags
    input  wire logic                 chain_reset_in_n_i,
    input  wire logic                 chain_reset_in_float_i,
    input  wire logic                 driver_enable_i,
    input  wire logic                 driver_enable_float_i,
    input  wire logic                 edge_rate_select_i,
    input  wire logic                 edge_rate_select_float_i,
    // Detector inputs
    input  wire logic                 input_signal_loss_i,
    input  wire logic                 term_fault_i,
    // Management bus pins
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe_o,
    // Fault flag, open drain
    output logic                      fault_o,
    output logic                      fault_oe_o,
    // Chain and analog controls
    output logic                      chain_release_out_o,
    output logic                      driver_on_o,
    output logic                      slow_edge_o,
    output logic                      los_offset_o,
    output logic                      los_mute_o,
    output logic [`TRIM_WIDTH-1:0]    amplitude_trim_o,
    // AXI4-Lite write address
    input  wire logic [7:0]           s_axi_awaddr_i,
    input  wire logic                 s_axi_awvalid_i,
    output logic                      s_axi_awready_o,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata_i,
    input  wire logic [3:0]           s_axi_wstrb_i,
    input  wire logic                 s_axi_wvalid_i,
    output logic                      s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp_o,
    output logic                      s_axi_bvalid_o,
    input  wire logic                 s_axi_bready_i,
    // AXI4-Lite read address
    input  wire logic [7:0]           s_axi_araddr_i,
    input  wire logic                 s_axi_arvalid_i,
    output logic                      s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata_o,
    output logic [1:0]                s_axi_rresp_o,
    output logic                      s_axi_rvalid_o,
    input  wire logic                 s_axi_rready_i
);
    import cable_driver_pkg::*;

    logic [9:0]              sync1_reg;
    logic [9:0]              sync2_reg;
    pin_level_t              pins;
    logic [`CTRL_WIDTH-1:0]  ctrl_reg;
    logic [`TRIM_WIDTH-1:0]  trim_reg;
    logic [6:0]              busaddr_reg;
    logic                    chain_reg;
    logic                    fault_reg;
    logic                    driver_on_reg;
    logic                    slow_edge_reg;
    logic                    mute_reg;
    logic                    offset_reg;
    logic [7:0]              aw_addr_reg;
    logic                    aw_have_reg;
    logic [7:0]              w_data_reg;
    logic                    w_strb_reg;
    logic                    w_have_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    rvalid_reg;
    logic [1:0]              rresp_reg;
    logic [31:0]             rdata_reg;
    smb_wr_t                 smb_wr;
    logic [7:0]              smb_idx;
    logic [7:0]              smb_rdata;
    logic                    axi_wr;
    logic                    wr_en;
    logic [7:0]              wr_addr;
    logic [7:0]              wr_data;
    logic                    wr_lane;
    logic                    fault_active;

    // True for the four mapped word offsets
    function automatic logic is_mapped(input logic [7:0] addr);
        return (addr == `OFS_CTRL) || (addr == `OFS_TRIM) || (addr == `OFS_STATUS) || (addr == `OFS_BUSADDR);
    endfunction

    // Undriven pin reads as its internal pull
    function automatic logic pin_level(input logic val, input logic floating, input logic pull);
        return floating ? pull : val;
    endfunction

    // Clamp to plus or minus TRIM_LIMIT steps
    function automatic logic [`TRIM_WIDTH-1:0] clamp_trim(input logic [`TRIM_WIDTH-1:0] v);
        logic signed [`TRIM_WIDTH-1:0] s;
        logic signed [`TRIM_WIDTH-1:0] lim;
        s   = v;
        lim = `TRIM_LIMIT;
        if (s > lim) begin
            return lim;
        end else if (s < -lim) begin
            return -lim;
        end
        return v;
    endfunction

    // Register read view shared by both buses
    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `OFS_CTRL:    v = {3'h0, ctrl_reg};
            `OFS_TRIM:    v = {2'h0, trim_reg};
            `OFS_STATUS: begin
                v[`STAT_LOS]       = pins.input_signal_loss;
                v[`STAT_TERM]      = pins.term;
                v[`STAT_CHAIN]     = chain_reg;
                v[`STAT_FAULT]     = fault_reg;
                v[`STAT_DRIVER_ON] = driver_on_reg;
                v[`STAT_SLOW_EDGE] = slow_edge_reg;
            end
            `OFS_BUSADDR: v = {1'h0, busaddr_reg};
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    // Two-stage synchroniser; reset to idle pin levels so no false pin reset follows
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 10'h280;
            sync2_reg <= 10'h280;
        end else begin
            sync1_reg <= {chain_reset_in_n_i, chain_reset_in_float_i, driver_enable_i, driver_enable_float_i,
                          edge_rate_select_i, edge_rate_select_float_i, input_signal_loss_i, term_fault_i,
                          2'h0};
            sync2_reg <= sync1_reg;
        end
    end

    assign pins.chain_reset_n = pin_level(sync2_reg[9], sync2_reg[8], `PULL_CHAIN_RESET);
    assign pins.enable        = pin_level(sync2_reg[7], sync2_reg[6], `PULL_ENABLE);
    assign pins.edge_rate     = pin_level(sync2_reg[5], sync2_reg[4], `PULL_EDGE_RATE);
    assign pins.input_signal_loss           = sync2_reg[3];
    assign pins.term          = sync2_reg[2];

    smbus_target u_smbus_target (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_oe_o   (sda_oe_o),
        .bus_addr_i (busaddr_reg),
        .rdata_i    (smb_rdata),
        .idx_o      (smb_idx),
        .wr_o       (smb_wr)
    );

    // Management register n is byte offset 4n
    assign smb_rdata = read_reg({smb_idx[5:0], 2'h0});
    assign sda_o     = 1'h0;

    // One shared write port; a management write wins and the AXI write waits a cycle
    assign axi_wr  = aw_have_reg && w_have_reg && !bvalid_reg && !smb_wr.valid;
    assign wr_en   = smb_wr.valid || axi_wr;
    assign wr_addr = smb_wr.valid ? {smb_wr.idx[5:0], 2'h0} : aw_addr_reg;
    assign wr_data = smb_wr.valid ? smb_wr.data : w_data_reg;
    assign wr_lane = smb_wr.valid || w_strb_reg;

    // Configuration registers; a low chain reset input holds every one at its default
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg    <= `CTRL_RESET;
            trim_reg    <= `TRIM_RESET;
            busaddr_reg <= `BUSADDR_RESET;
        end else if (!pins.chain_reset_n) begin
            ctrl_reg    <= `CTRL_RESET;
            trim_reg    <= `TRIM_RESET;
            busaddr_reg <= `BUSADDR_RESET;
        end else if (wr_en && wr_lane) begin
            case (wr_addr)
                `OFS_CTRL:    ctrl_reg    <= wr_data[`CTRL_WIDTH-1:0];
                `OFS_TRIM:    trim_reg    <= clamp_trim(wr_data[`TRIM_WIDTH-1:0]);
                `OFS_BUSADDR: busaddr_reg <= wr_data[6:0];
                default: ;
            endcase
        end
    end

    // Chain output: set by any write to offset zero, cleared by the pin
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chain_reg <= 1'h0;
        end else if (!pins.chain_reset_n) begin
            chain_reg <= 1'h0;
        end else if (wr_en && (wr_addr == `OFS_CTRL)) begin
            chain_reg <= 1'h1;
        end
    end

    assign fault_active = (pins.input_signal_loss  && !ctrl_reg[`CTRL_MASK_LOS]) ||
                          (pins.term && !ctrl_reg[`CTRL_MASK_TERM]);

    // Analog controls and flag, all registered so they cannot glitch
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_reg     <= 1'h0;
            driver_on_reg <= 1'h1;
            slow_edge_reg <= 1'h0;
            mute_reg      <= 1'h0;
            offset_reg    <= 1'h0;
        end else begin
            fault_reg     <= fault_active;
            // Loss powers down only when enabled
            driver_on_reg <= pins.enable && !(pins.input_signal_loss && ctrl_reg[`CTRL_LOS_PWRDN]);
            // Register bit counts only while the pin is low
            slow_edge_reg <= pins.edge_rate ? 1'h1 : ctrl_reg[`CTRL_SLOW_EDGE];
            mute_reg      <= pins.input_signal_loss && ctrl_reg[`CTRL_LOS_MUTE];
            offset_reg    <= pins.input_signal_loss && !ctrl_reg[`CTRL_LOS_MUTE];
        end
    end

    // AW and W taken independently; response follows both
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_reg <= 1'h0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_reg <= 1'h1;
            aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
        end else if (axi_wr) begin
            aw_have_reg <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_have_reg <= 1'h0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_reg <= 1'h1;
            w_data_reg <= s_axi_wdata_i[7:0];
            w_strb_reg <= s_axi_wstrb_i[0];
        end else if (axi_wr) begin
            w_have_reg <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_reg <= 1'h0;
            bresp_reg  <= `RESP_OKAY;
        end else if (axi_wr) begin
            bvalid_reg <= 1'h1;
            bresp_reg  <= is_mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'h0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_reg <= 1'h0;
            rresp_reg  <= `RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_reg <= 1'h1;
            rresp_reg  <= is_mapped({s_axi_araddr_i[7:2], 2'h0}) ? `RESP_OKAY : `RESP_SLVERR;
            rdata_reg  <= {24'h00_0000, read_reg({s_axi_araddr_i[7:2], 2'h0})};
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'h0;
        end
    end

    assign s_axi_awready_o = !aw_have_reg;
    assign s_axi_wready_o  = !w_have_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign s_axi_rdata_o   = rdata_reg;

    // Flag only ever pulls low so several drivers can share one line
    assign fault_o             = 1'h0;
    assign fault_oe_o          = fault_reg;
    assign chain_release_out_o = chain_reg;
    assign driver_on_o         = driver_on_reg;
    assign slow_edge_o         = slow_edge_reg;
    assign los_mute_o          = mute_reg;
    assign los_offset_o        = offset_reg;
    assign amplitude_trim_o    = trim_reg;
    // Clock pin is only sampled, there is no output for it

endmodule // cable_driver_ctrl

// ==== verification/cable_driver_ctrl_assertions.sv ====
/* Pin-level checker for the cable driver control logic.
   Assumes it is bound to cable_driver_ctrl and sees only its ports. */
module cd_checker (
    // Clock, reset, pins and flags
    input wire logic ref_clk_i, rst_n_i, chain_reset_in_n_i, chain_reset_in_float_i,
    input wire logic driver_enable_i, driver_enable_float_i, edge_rate_select_i, edge_rate_select_float_i,
    input wire logic input_signal_loss_i, term_fault_i, sda_o, fault_o, fault_oe_o,
    input wire logic chain_release_out_o, driver_on_o, slow_edge_o, los_offset_o, los_mute_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Two sync flops and a register: three edges
    a_fault_od: assert property (fault_o == 1'h0)
        else $error("fault line driven high");
    a_sda_od: assert property (sda_o == 1'h0)
        else $error("data line driven high");
    a_chain_clear: assert property ((!chain_reset_in_n_i && !chain_reset_in_float_i) [*3] |=> !chain_release_out_o)
        else $error("chain output not cleared");
    a_drv_off: assert property ((!driver_enable_i && !driver_enable_float_i) [*3] |=> !driver_on_o)
        else $error("driver not powered off");
    a_drv_float: assert property ((driver_enable_float_i && !input_signal_loss_i) [*4] |=> driver_on_o)
        else $error("floating enable not high");
    a_slow_pin: assert property ((edge_rate_select_i && !edge_rate_select_float_i) [*3] |=> slow_edge_o)
        else $error("slow edges not chosen");
    a_fault_rel: assert property ((!input_signal_loss_i && !term_fault_i) [*3] |=> !fault_oe_o)
        else $error("fault flag not released");
    a_los_quiet: assert property (!input_signal_loss_i [*3] |=> !los_offset_o && !los_mute_o)
        else $error("loss action without loss");
    cover property ($rose(chain_release_out_o));
    cover property ($rose(fault_oe_o));
    cover property ($rose(los_mute_o));
endmodule // cd_checker

bind cable_driver_ctrl cd_checker u_chk (.*);

// ==== verification/pin_env.sv ====
/* Far side of the open-drain lines: pull-ups on the data, clock and fault wires.
   Assumes the management bus is idle, so the clock stands still high. */
module pin_env (
    // Enables from the device
    input  wire logic sda_oe_i,
    input  wire logic fault_oe_i,
    // Wire levels
    output logic      sda_o,
    output logic      scl_o,
    output logic      fault_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign sda_o = !sda_oe_i;
    assign scl_o = 1'h1;
    assign fault_n_o = !fault_oe_i;
endmodule // pin_env

// ==== verification/tb.sv ====
/* Register and pin tests of the cable driver control logic.
   Assumes core/ is on the include path; pin_env models the pull-ups. */
`include "cable_driver_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cable_driver_pkg::*;
    logic        clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0, brdy = 1'h0, rrdy = 1'h0;
    logic [7:0]  aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, rdata, tw[4] = '{32'h14, 32'h10, 32'h2C, 32'h3F}, te[4] = '{32'h10, 32'h10, 32'h30, 32'h3F};
    pin_level_t  pin = 5'h05, flt = 5'h00;
    logic        awr, wr_, bv, arr, rv, sda_oe, sda_w, scl_w, fault_oe, flt_n, chain, drv, slow, loff, lmute;
    logic [1:0]  bresp, rresp;
    logic [5:0]  trim;
    int          mismatches = 0, checked = 0;
    always #25 clk = ~clk;
    pin_env ENV (.sda_oe_i(sda_oe), .fault_oe_i(fault_oe), .sda_o(sda_w), .scl_o(scl_w), .fault_n_o(flt_n));
    cable_driver_ctrl DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .chain_reset_in_n_i(pin.chain_reset_n),
        .chain_reset_in_float_i(flt.chain_reset_n), .driver_enable_i(pin.enable), .driver_enable_float_i(flt.enable),
        .edge_rate_select_i(pin.edge_rate), .edge_rate_select_float_i(flt.edge_rate), .input_signal_loss_i(pin.input_signal_loss),
        .term_fault_i(pin.term), .scl_i(scl_w), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .fault_o(),
        .fault_oe_o(fault_oe), .chain_release_out_o(chain), .driver_on_o(drv), .slow_edge_o(slow),
        .los_offset_o(loff), .los_mute_o(lmute), .amplitude_trim_o(trim), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(brdy), .s_axi_araddr_i(ar),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        aw <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        brdy <= 1'h1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wr_) wv <= 1'h0;
        end while (!bv);
        brdy <= 1'h0;
        chk("bresp", r, bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        ar <= a;
        arv <= 1'h1;
        rrdy <= 1'h1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'h0;
        end while (!rv);
        rrdy <= 1'h0;
        chk("rdata", e, rdata);
        chk("rresp", r, rresp);
    endtask
    // Sync flops plus output register
    task automatic tick;
        repeat (5) @(posedge clk);
    endtask
    task automatic results;
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #300000;
        mismatches++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        rd(`OFS_CTRL, 32'h00, `RESP_OKAY);
        rd(`OFS_BUSADDR, 32'h17, `RESP_OKAY);
        rd(`OFS_STATUS, 32'h10, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h00, `RESP_OKAY);
        tick();
        chk("chain", 1'h1, chain);
        foreach (tw[i]) begin
            wr(`OFS_TRIM, tw[i], `RESP_OKAY);
            rd(`OFS_TRIM, te[i], `RESP_OKAY);
        end
        chk("trim", 6'h3F, trim);
        wr(8'h10, 32'h01, `RESP_SLVERR);
        rd(8'h10, 32'h00, `RESP_SLVERR);
        pin.input_signal_loss <= 1'h1;
        tick();
        chk("fault", 1'h0, flt_n);
        chk("offset", 1'h1, loff);
        rd(`OFS_STATUS, 32'h1D, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h0A, `RESP_OKAY);
        tick();
        chk("fault", 1'h1, flt_n);
        chk("mute", 1'h1, lmute);
        rd(`OFS_STATUS, 32'h15, `RESP_OKAY);
        wr(`OFS_CTRL, 32'h04, `RESP_OKAY);
        tick();
        chk("driver", 1'h0, drv);
        pin.input_signal_loss <= 1'h0;
        pin.term <= 1'h1;
        tick();
        chk("fault", 1'h0, flt_n);
        wr(`OFS_CTRL, 32'h11, `RESP_OKAY);
        tick();
        chk("fault", 1'h1, flt_n);
        chk("slow", 1'h1, slow);
        pin.term <= 1'h0;
        wr(`OFS_CTRL, 32'h00, `RESP_OKAY);
        tick();
        chk("slow", 1'h0, slow);
        pin.edge_rate <= 1'h1;
        tick();
        chk("slow", 1'h1, slow);
        flt.edge_rate <= 1'h1;
        tick();
        chk("slow", 1'h0, slow);
        pin.enable <= 1'h0;
        tick();
        chk("driver", 1'h0, drv);
        flt.enable <= 1'h1;
        tick();
        chk("driver", 1'h1, drv);
        pin.chain_reset_n <= 1'h0;
        tick();
        chk("chain", 1'h0, chain);
        wr(`OFS_CTRL, 32'h01, `RESP_OKAY);
        rd(`OFS_CTRL, 32'h00, `RESP_OKAY);
        flt.chain_reset_n <= 1'h1;
        tick();
        wr(`OFS_CTRL, 32'h00, `RESP_OKAY);
        tick();
        chk("chain", 1'h1, chain);
        results();
    end
endmodule // tb
